// File: logic/rps_pkg.sv
package rps_pkg;
    // ==========================================================
    // clock and timing
    localparam int unsigned CLOCK_HZ           = 10_000_000;
    localparam int unsigned POR_HOLD_MAX_MS    = 110;
    localparam int unsigned OFF_GAP_MIN_MS     = 10;
    localparam int unsigned HOST_WAIT_MIN_MS   = 150;
    localparam int unsigned CYCLES_PER_MS      = CLOCK_HZ / 1000;
    // longest time: round down
    localparam int unsigned POR_HOLD_CYCLES    = POR_HOLD_MAX_MS * CYCLES_PER_MS;
    // least times: round up
    localparam int unsigned OFF_GAP_CYCLES     = (OFF_GAP_MIN_MS * CLOCK_HZ + 999) / 1000;
    localparam int unsigned HOST_WAIT_CYCLES   = (HOST_WAIT_MIN_MS * CLOCK_HZ + 999) / 1000;
    localparam int unsigned CNT_W              = 24;
    localparam logic [1:0]  SYNC_RESET         = 2'h0;
endpackage : rps_pkg

// File: logic/rps_sync_if.sv
`timescale 1ns/1ns
interface rps_sync_if;
    logic wlanRaw;
    logic radioRaw;
    logic wlanSync;
    logic radioSync;
    modport sync (input wlanRaw, input radioRaw, output wlanSync, output radioSync);
    modport user (output wlanRaw, output radioRaw, input wlanSync, input radioSync);
endinterface : rps_sync_if

// File: logic/rps_enable_sync.sv
`timescale 1ns/1ns
module rps_enable_sync (
    input  wire logic clock,
    input  wire logic rst_b,
    rps_sync_if.sync  link
);
    typedef struct packed {
        logic [1:0] wlanSh;
        logic [1:0] radioSh;
    } rps_sync_state_t;

    rps_sync_state_t state_q;
    rps_sync_state_t state_d;

    always_comb begin
        state_d         = state_q;
        state_d.wlanSh  = {state_q.wlanSh[0], link.wlanRaw};
        state_d.radioSh = {state_q.radioSh[0], link.radioRaw};
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            state_q <= '{wlanSh: rps_pkg::SYNC_RESET, radioSh: rps_pkg::SYNC_RESET};
        end else begin
            state_q <= state_d;
        end
    end

    // only the second stage leaves this module
    assign link.wlanSync  = state_q.wlanSh[1];
    assign link.radioSync = state_q.radioSh[1];
endmodule : rps_enable_sync

// File: logic/rps_sequencer.sv
`timescale 1ns/1ns
// Functional notes
// - regulators on when either enable high
// - wlan section reset follows wlan enable once chip reset released
// - both enables low disables all regulators
// - radio held reset while its enable low
// - power-on reset held at most 110 ms
module rps_sequencer #(
    parameter int unsigned POR_CYCLES  = rps_pkg::POR_HOLD_CYCLES,
    parameter int unsigned GAP_CYCLES  = rps_pkg::OFF_GAP_CYCLES,
    parameter int unsigned WAIT_CYCLES = rps_pkg::HOST_WAIT_CYCLES
) (
    input  wire logic clock,
    input  wire logic rst_b,
    input  wire logic suppliesValid,
    input  wire logic wlanPowerEnable,
    input  wire logic radioPowerEnable,
    output logic      regulatorEnable,
    output logic      wlanReset_b,
    output logic      radioReset_b,
    output logic      chipReset_b,
    output logic      hostAccessReady,
    output logic      offGapViolation
);
    // ==========================================================
    // types and state
    typedef enum logic [1:0] {
        ST_NO_SUPPLY = 2'h0,
        ST_POR_HOLD  = 2'h1,
        ST_RUN       = 2'h2
    } rps_phase_t;

    typedef struct packed {
        rps_phase_t                 phase;
        logic [rps_pkg::CNT_W-1:0]  porCnt;
        logic [rps_pkg::CNT_W-1:0]  waitCnt;
        logic [rps_pkg::CNT_W-1:0]  gapCnt;
        logic                       gapActive;
        logic                       anyPrev;
        logic                       regEn;
        logic                       wlanRstB;
        logic                       radioRstB;
        logic                       chipRstB;
        logic                       hostReady;
        logic                       gapViol;
    } rps_state_t;

    rps_state_t state_q;
    rps_state_t state_d;

    // everything off, no supply seen yet
    localparam rps_state_t STATE_RESET = '{
        phase:     ST_NO_SUPPLY,
        porCnt:    '0,
        waitCnt:   '0,
        gapCnt:    '0,
        gapActive: 1'h0,
        anyPrev:   1'h0,
        regEn:     1'h0,
        wlanRstB:  1'h0,
        radioRstB: 1'h0,
        chipRstB:  1'h0,
        hostReady: 1'h0,
        gapViol:   1'h0
    };

    // ==========================================================
    // counter and decode helpers
    function automatic logic cnt_at(input logic [rps_pkg::CNT_W-1:0] c,
                                    input int unsigned               lim);
        logic [rps_pkg::CNT_W-1:0] limW;
        limW   = lim[rps_pkg::CNT_W-1:0];
        cnt_at = (c >= limW);
    endfunction : cnt_at

    // saturating count: holds once the limit is reached
    function automatic logic [rps_pkg::CNT_W-1:0] cnt_inc(input logic [rps_pkg::CNT_W-1:0] c,
                                                          input int unsigned               lim);
        if (cnt_at(c, lim)) begin
            cnt_inc = c;
        end else begin
            cnt_inc = c + 1'b1;
        end
    endfunction : cnt_inc

    // supply loss wins over the end of the hold
    function automatic rps_phase_t phase_step(input rps_phase_t cur,
                                              input logic       supplies,
                                              input logic       porDone);
        phase_step = cur;
        if (!supplies) begin
            phase_step = ST_NO_SUPPLY;
        end else if (porDone) begin
            phase_step = ST_RUN;
        end
    endfunction : phase_step

    // a section leaves reset only with the chip out of reset
    function automatic logic section_release(input logic chipOut,
                                             input logic enable);
        section_release = chipOut & enable;
    endfunction : section_release

    // ==========================================================
    // input synchroniser
    rps_sync_if syncLink ();
    assign syncLink.wlanRaw  = wlanPowerEnable;
    assign syncLink.radioRaw = radioPowerEnable;

    rps_enable_sync u_sync (
        .clock (clock),
        .rst_b (rst_b),
        .link  (syncLink)
    );

    logic wlanEn;
    logic radioEn;
    logic anyEn;
    assign wlanEn  = syncLink.wlanSync;
    assign radioEn = syncLink.radioSync;
    assign anyEn   = wlanEn | radioEn;

    // ==========================================================
    // next state
    always_comb begin
        state_d         = state_q;
        state_d.anyPrev = anyEn;
        state_d.gapViol = 1'h0;

        // ==========================================================
        // power-on phase
        case (state_q.phase)
            ST_NO_SUPPLY: begin
                state_d.porCnt  = '0;
                state_d.waitCnt = '0;
                if (suppliesValid) begin
                    state_d.phase = ST_POR_HOLD;
                end else begin
                    state_d.phase = ST_NO_SUPPLY;
                end
            end
            ST_POR_HOLD: begin
                state_d.porCnt  = cnt_inc(state_q.porCnt, POR_CYCLES);
                state_d.waitCnt = cnt_inc(state_q.waitCnt, WAIT_CYCLES);
                state_d.phase   = phase_step(state_q.phase,
                                             suppliesValid,
                                             cnt_at(state_d.porCnt, POR_CYCLES));
            end
            ST_RUN: begin
                state_d.waitCnt = cnt_inc(state_q.waitCnt, WAIT_CYCLES);
                state_d.phase   = phase_step(state_q.phase, suppliesValid, 1'h1);
            end
            default: begin
                state_d.phase = ST_NO_SUPPLY;
            end
        endcase

        // ==========================================================
        // off-gap watch: longer gaps are always fine
        if (state_q.anyPrev && !anyEn) begin
            // both enables just went low
            state_d.gapActive = 1'h1;
            state_d.gapCnt    = '0;
        end else if (state_q.gapActive && anyEn) begin
            // an enable came back: flag a short gap
            state_d.gapActive = 1'h0;
            state_d.gapViol   = !cnt_at(state_q.gapCnt, GAP_CYCLES);
        end else if (state_q.gapActive) begin
            state_d.gapCnt = cnt_inc(state_q.gapCnt, GAP_CYCLES);
        end

        // ==========================================================
        // output levels
        state_d.chipRstB  = (state_d.phase == ST_RUN);
        state_d.regEn     = anyEn;
        state_d.wlanRstB  = section_release(state_d.chipRstB, wlanEn);
        state_d.radioRstB = section_release(state_d.chipRstB, radioEn);
        state_d.hostReady = state_d.chipRstB & cnt_at(state_d.waitCnt, WAIT_CYCLES);
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            state_q <= STATE_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    // ==========================================================
    // outputs
    assign regulatorEnable = state_q.regEn;
    assign wlanReset_b     = state_q.wlanRstB;
    assign radioReset_b    = state_q.radioRstB;
    assign chipReset_b     = state_q.chipRstB;
    assign hostAccessReady = state_q.hostReady;
    assign offGapViolation = state_q.gapViol;
endmodule : rps_sequencer

// File: tb/rps_sequencer_asserts.sv
`timescale 1ns/1ns
module rps_sequencer_asserts #(
    parameter int POR_CYCLES = 20
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic suppliesValid,
    input wire logic wlanPowerEnable,
    input wire logic radioPowerEnable,
    input wire logic regulatorEnable,
    input wire logic wlanReset_b,
    input wire logic radioReset_b,
    input wire logic chipReset_b,
    input wire logic hostAccessReady,
    input wire logic offGapViolation
);
    localparam int PorLim = POR_CYCLES + 2;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    // ====
    // pin paths
    property p_reg; regulatorEnable == ($past(wlanPowerEnable, 3) || $past(radioPowerEnable, 3)); endproperty
    property p_off; !wlanPowerEnable && !radioPowerEnable |-> ##3 !regulatorEnable; endproperty
    property p_wlan; wlanReset_b == (chipReset_b && $past(wlanPowerEnable, 3)); endproperty
    property p_radio; radioReset_b == (chipReset_b && $past(radioPowerEnable, 3)); endproperty
    property p_por; $rose(suppliesValid) |-> ##[1:PorLim] (chipReset_b || !suppliesValid); endproperty
    property p_drop; !suppliesValid |=> !chipReset_b; endproperty
    property p_host; hostAccessReady |-> chipReset_b; endproperty
    property p_gap; offGapViolation |=> !offGapViolation; endproperty
    a_reg: assert property (p_reg) else $error("regulator enable wrong");
    a_off: assert property (p_off) else $error("regulator still on");
    a_wlan: assert property (p_wlan) else $error("wlan reset wrong");
    a_radio: assert property (p_radio) else $error("radio reset wrong");
    a_por: assert property (p_por) else $error("power-on hold too long");
    a_drop: assert property (p_drop) else $error("chip reset kept");
    a_host: assert property (p_host) else $error("host ready early");
    a_gap: assert property (p_gap) else $error("gap pulse too long");
    c_chip: cover property ($rose(chipReset_b));
    c_host: cover property ($rose(hostAccessReady));
    c_gap: cover property (offGapViolation);
endmodule : rps_sequencer_asserts
bind rps_sequencer rps_sequencer_asserts #(.POR_CYCLES(POR_CYCLES)) chk (
    .clock(clock), .rst_b(rst_b), .suppliesValid(suppliesValid), .wlanPowerEnable(wlanPowerEnable),
    .radioPowerEnable(radioPowerEnable), .regulatorEnable(regulatorEnable), .wlanReset_b(wlanReset_b),
    .radioReset_b(radioReset_b), .chipReset_b(chipReset_b), .hostAccessReady(hostAccessReady),
    .offGapViolation(offGapViolation)
);

// File: tb/rps_host_model.sv
`timescale 1ns/1ns
module rps_host_model #(
    parameter int GAP = 10
) (
    input  wire logic       clock,
    input  wire logic [1:0] want,
    input  wire logic       rude,
    output logic            wlanPowerEnable,
    output logic            radioPowerEnable
);
    int idle = 0;
    initial {wlanPowerEnable, radioPowerEnable} = 2'h0;
    // ====
    // both low: let the buck discharge unless told to be rude
    always @(negedge clock) begin
        idle = (wlanPowerEnable || radioPowerEnable) ? 0 : idle + 1;
        if (rude || wlanPowerEnable || radioPowerEnable || idle > GAP + 1)
            {wlanPowerEnable, radioPowerEnable} <= want;
    end
endmodule : rps_host_model

// File: tb/test_radio_power_reset_sequencer.sv
`timescale 1ns/1ns
module test_radio_power_reset_sequencer;
    localparam int POR = 20;
    localparam int GAP = 10;
    localparam int WAIT = 30;
    logic       clock = 1'b0, rst_b = 1'b0, suppliesValid = 1'b0, rude = 1'b0;
    logic [1:0] want = 2'h0, n;
    logic       wlanPowerEnable, radioPowerEnable, regulatorEnable, wlanReset_b;
    logic       radioReset_b, chipReset_b, hostAccessReady, offGapViolation;
    logic [1:0] notes[$];
    int         fails = 0, check_count = 0, up = 0, pulses = 0;
    always #50 clock = ~clock;
    rps_host_model #(.GAP(GAP)) host (.clock(clock), .want(want), .rude(rude),
        .wlanPowerEnable(wlanPowerEnable), .radioPowerEnable(radioPowerEnable));
    rps_sequencer #(.POR_CYCLES(POR), .GAP_CYCLES(GAP), .WAIT_CYCLES(WAIT)) dut (.clock(clock), .rst_b(rst_b),
        .suppliesValid(suppliesValid), .wlanPowerEnable(wlanPowerEnable), .radioPowerEnable(radioPowerEnable),
        .regulatorEnable(regulatorEnable), .wlanReset_b(wlanReset_b), .radioReset_b(radioReset_b),
        .chipReset_b(chipReset_b), .hostAccessReady(hostAccessReady), .offGapViolation(offGapViolation));
    task automatic cmp(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("FAIL %0t output mismatch", $time);
        end
    endtask : cmp
    task automatic print_verdict;
        if (fails == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict
    task automatic step(input logic [1:0] w, input int cyc);
        want <= w;
        repeat (cyc) @(negedge clock);
    endtask : step
    // ====
    // pin notes, checked two rising edges later
    always @(posedge clock) begin
        up <= (rst_b && suppliesValid) ? up + 1 : 0;
        if (rst_b)
            notes.push_back({wlanPowerEnable, radioPowerEnable});
    end
    always @(negedge clock) begin
        pulses += int'(offGapViolation === 1'b1);
        if (notes.size() > 2) begin
            n = notes.pop_front();
            cmp(regulatorEnable, n[1] | n[0]);
            cmp(wlanReset_b, n[1] && up >= POR + 1);
            cmp(radioReset_b, n[0] && up >= POR + 1);
            cmp(chipReset_b, up >= POR + 1);
            cmp(hostAccessReady, up >= WAIT + 1);
        end
    end
    initial begin
        #1_000_000;
        fails++;
        print_verdict;
    end
    initial begin
        void'($urandom(10));
        repeat (5) @(negedge clock);
        rst_b = 1'b1;
        repeat (30) step(2'($urandom), 4);
        suppliesValid = 1'b1;
        repeat (150) step(2'($urandom), $urandom_range(1, 6));
        cmp(pulses == 0, 1'b1);
        rude <= 1'b1;
        step(2'h2, 4);
        step(2'h0, 3);
        step(2'h3, 8);
        cmp(pulses > 0, 1'b1);
        suppliesValid = 1'b0;
        step(2'h1, 8);
        print_verdict;
    end
endmodule : test_radio_power_reset_sequencer
